// file: core/ppm_pkg.sv
package ppm_pkg;

  localparam int unsigned PPM_NPINS     = 6;
  localparam int unsigned PPM_AW        = 8;

  // Register byte offsets on the APB slave
  localparam logic [7:0]  PPM_OFF_LATCH = 8'h00;
  localparam logic [7:0]  PPM_OFF_DIR   = 8'h04;
  localparam logic [7:0]  PPM_OFF_PIN   = 8'h08;
  localparam logic [7:0]  PPM_OFF_MCU   = 8'h0c;

  // Control register field positions
  localparam int unsigned PPM_MCU_ISC_LO = 0;
  localparam int unsigned PPM_MCU_ISC_HI = 1;
  localparam int unsigned PPM_MCU_SM_LO  = 3;
  localparam int unsigned PPM_MCU_SM_HI  = 4;
  localparam int unsigned PPM_MCU_SE     = 5;
  localparam int unsigned PPM_MCU_PUD    = 6;

  // Bits 7 and 2 are not writable and read as zero
  localparam logic [7:0]  PPM_MCU_WMASK  = 8'h7b;
  localparam logic [7:0]  PPM_MCU_RST    = 8'h00;
  localparam logic        PPM_BIT_RST    = 1'b0;

  // {direction, latch, pull-up disable} that turns the pull-up on
  localparam logic [2:0]  PPM_PU_PATTERN = 3'h2;

  typedef struct packed {
    logic pullup_override_en;
    logic pullup_override_val;
    logic dir_override_en;
    logic dir_override_val;
    logic outval_override_en;
    logic outval_override_val;
    logic toggle_override_en;
    logic input_en_override_en;
    logic input_en_override_val;
  } ppm_ovr_t;

endpackage : ppm_pkg

// file: core/ppm_port_mux.sv
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module ppm_port_mux
  import ppm_pkg::*;
#(
  parameter int unsigned NPINS = PPM_NPINS
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic [PPM_AW-1:0]   paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [NPINS-1:0]    pad_in,
  output logic      [NPINS-1:0]    pad_out,
  output logic      [NPINS-1:0]    pad_oe,
  output logic      [NPINS-1:0]    pad_pullup_en,
  output logic      [NPINS-1:0]    pad_analog_tap,
  input  wire ppm_ovr_t [NPINS-1:0] ovr,
  input  wire logic                sleep_clamp,
  output logic      [NPINS-1:0]    alt_fn_raw_input,
  output logic                     global_pullup_disable,
  output logic                     sleep_enable_bit,
  output logic      [1:0]          sleep_mode,
  output logic      [1:0]          ext_irq_sense
);

  function automatic logic ppm_hit(input logic [PPM_AW-1:0] a,
                                   input logic [PPM_AW-1:0] off);
    return a == off;
  endfunction : ppm_hit

  logic [NPINS-1:0] latch_q;
  logic [NPINS-1:0] latch_d;
  logic [NPINS-1:0] dir_q;
  logic [NPINS-1:0] sync1_q;
  logic [NPINS-1:0] pin_q;
  logic [7:0]       mcu_q;
  logic [31:0]      rdata_q;
  logic [31:0]      rdata_d;
  logic             err_q;

  logic             setup_ph;
  logic             acc_wr;
  logic             hit_latch;
  logic             hit_dir;
  logic             hit_pin;
  logic             hit_mcu;
  logic             unmapped;
  logic             latch_write_strobe;
  logic             input_reg_write_strobe;
  logic             direction_write_strobe;
  logic             mcu_write_strobe;
  logic             latch_read_strobe;
  logic             pin_read_strobe;
  logic             direction_read_strobe;
  logic             mcu_read_strobe;
  logic [NPINS-1:0] wdata_pins;
  logic [NPINS-1:0] toggle_vec;
  logic [NPINS-1:0] din;

  assign setup_ph  = psel & ~penable;
  assign acc_wr    = psel & penable & pwrite;
  assign hit_latch = ppm_hit(paddr, PPM_OFF_LATCH);
  assign hit_dir   = ppm_hit(paddr, PPM_OFF_DIR);
  assign hit_pin   = ppm_hit(paddr, PPM_OFF_PIN);
  assign hit_mcu   = ppm_hit(paddr, PPM_OFF_MCU);
  assign unmapped  = ~(hit_latch | hit_dir | hit_pin | hit_mcu);

  assign latch_write_strobe     = acc_wr & hit_latch;
  assign input_reg_write_strobe = acc_wr & hit_pin;
  assign direction_write_strobe = acc_wr & hit_dir;
  assign mcu_write_strobe       = acc_wr & hit_mcu;
  assign latch_read_strobe      = setup_ph & ~pwrite & hit_latch;
  assign pin_read_strobe        = setup_ph & ~pwrite & hit_pin;
  assign direction_read_strobe  = setup_ph & ~pwrite & hit_dir;
  assign mcu_read_strobe        = setup_ph & ~pwrite & hit_mcu;

  assign wdata_pins = pwdata[NPINS-1:0];

  // Read data is latched in the setup cycle so the slave never waits
  assign pready  = 1'b1;
  assign prdata  = rdata_q;
  assign pslverr = psel & penable & err_q;

  always_comb begin
    rdata_d = '0;
    if (latch_read_strobe) begin
      rdata_d[NPINS-1:0] = latch_q;
    end else if (direction_read_strobe) begin
      rdata_d[NPINS-1:0] = dir_q;
    end else if (pin_read_strobe) begin
      rdata_d[NPINS-1:0] = pin_q;
    end else if (mcu_read_strobe) begin
      rdata_d[7:0] = mcu_q & PPM_MCU_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
      err_q   <= 1'b0;
    end else if (setup_ph) begin
      rdata_q <= rdata_d;
      err_q   <= unmapped;
    end
  end

  // Control register, pull-up disable at bit 6
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcu_q <= PPM_MCU_RST;
    end else if (mcu_write_strobe) begin
      mcu_q <= pwdata[7:0] & PPM_MCU_WMASK;
    end
  end

  assign global_pullup_disable = mcu_q[PPM_MCU_PUD];
  assign sleep_enable_bit      = mcu_q[PPM_MCU_SE];
  assign sleep_mode            = {mcu_q[PPM_MCU_SM_HI], mcu_q[PPM_MCU_SM_LO]};
  assign ext_irq_sense         = {mcu_q[PPM_MCU_ISC_HI], mcu_q[PPM_MCU_ISC_LO]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= {NPINS{PPM_BIT_RST}};
    end else if (direction_write_strobe) begin
      dir_q <= wdata_pins;
    end
  end

  always_comb begin
    latch_d = latch_write_strobe ? wdata_pins : latch_q;
    if (input_reg_write_strobe) begin
      latch_d = latch_d ^ wdata_pins;
    end
    // Peripheral toggle applies after any write
    latch_d = latch_d ^ toggle_vec;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q <= {NPINS{PPM_BIT_RST}};
    end else begin
      latch_q <= latch_d;
    end
  end

  // Clamped input costs two cycles of latency before software sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      pin_q   <= '0;
    end else begin
      sync1_q <= din;
      pin_q   <= sync1_q;
    end
  end

  // Override inputs arrive ready-made per pin
  for (genvar i = 0; i < NPINS; i++) begin : g_pin
    logic pu_plain;
    logic oe;
    logic ie;

    assign pu_plain = ({dir_q[i], latch_q[i], global_pullup_disable} == PPM_PU_PATTERN);

    assign pad_pullup_en[i] = ovr[i].pullup_override_en ? ovr[i].pullup_override_val
                                                        : pu_plain;

    assign oe = ovr[i].dir_override_en ? ovr[i].dir_override_val : dir_q[i];
    assign pad_oe[i] = oe;

    assign pad_out[i] = oe & (ovr[i].outval_override_en ? ovr[i].outval_override_val
                                                        : latch_q[i]);

    assign toggle_vec[i] = ovr[i].toggle_override_en;

    assign ie = ovr[i].input_en_override_en ? ovr[i].input_en_override_val
                                            : ~sleep_clamp;
    assign din[i] = pad_in[i] & ie;

    assign alt_fn_raw_input[i] = din[i];

    // Analog tap; only the pad-to-peripheral sense is modelled
    assign pad_analog_tap[i] = pad_in[i];
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  for (genvar k = 0; k < NPINS; k++) begin : g_chk
    AST_PU_OVR: assert property (ovr[k].pullup_override_en
        |-> pad_pullup_en[k] == ovr[k].pullup_override_val)
      else $error("pull-up ignores override value");

    AST_PU_PLAIN: assert property (!ovr[k].pullup_override_en
        |-> pad_pullup_en[k] == (!dir_q[k] && latch_q[k] && !mcu_q[6]))
      else $error("plain pull-up pattern wrong");

    AST_PUD_OFF: assert property (mcu_q[6] && !ovr[k].pullup_override_en
        |-> !pad_pullup_en[k])
      else $error("pull-up on while globally disabled");

    AST_DIR: assert property (!ovr[k].dir_override_en |-> pad_oe[k] == dir_q[k])
      else $error("driver does not follow direction");

    AST_DIR_OVR: assert property (ovr[k].dir_override_en
        |-> pad_oe[k] == ovr[k].dir_override_val)
      else $error("driver ignores direction override");

    AST_VAL_OVR: assert property (pad_oe[k] && ovr[k].outval_override_en
        |-> pad_out[k] == ovr[k].outval_override_val)
      else $error("pin value ignores override");

    AST_VAL_LATCH: assert property (pad_oe[k] && !ovr[k].outval_override_en
        |-> pad_out[k] == latch_q[k])
      else $error("pin value differs from latch");

    AST_TOGGLE: assert property (ovr[k].toggle_override_en && !latch_write_strobe
        && !input_reg_write_strobe |=> latch_q[k] != $past(latch_q[k]))
      else $error("toggle override did not invert latch");

    AST_SLEEP: assert property (sleep_clamp && !ovr[k].input_en_override_en
        |-> !alt_fn_raw_input[k])
      else $error("input not clamped in sleep");

    AST_SYNC: assert property (##2 pin_q[k] == $past(alt_fn_raw_input[k], 2))
      else $error("pin register latency not two cycles");
  end

  AST_PIN_WR: assert property (input_reg_write_strobe && toggle_vec == '0
      |=> latch_q == ($past(latch_q) ^ $past(wdata_pins)))
    else $error("pin register write did not toggle latch");

  AST_RSVD: assert property (mcu_q[7] == 1'b0 && mcu_q[2] == 1'b0)
    else $error("reserved control bit set");

  AST_PUD_WR: assert property (mcu_write_strobe
      |=> global_pullup_disable == $past(pwdata[6]))
    else $error("pull-up disable not written");

endmodule : ppm_port_mux

`default_nettype wire

// file: tb/ppm_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppm_periph_model
  import ppm_pkg::*;
#(
  parameter int unsigned NPINS = PPM_NPINS
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire ppm_ovr_t [NPINS-1:0] req,
  output var  ppm_ovr_t [NPINS-1:0] ovr
);
  // own override generation
  // Registered so overrides move one edge after the request, as a peripheral flop would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ovr <= '0;
    else
      ovr <= req;
  end
endmodule : ppm_periph_model
`default_nettype wire

// file: tb/tb_ppm_port_mux.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ppm_port_mux;
  import ppm_pkg::*;
  localparam int unsigned N = PPM_NPINS;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic                 sleep_clamp, gpd, se;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata, rd;
  logic [N-1:0]         pad_in, pad_out, pad_oe, pad_pu, pad_an, alt_raw;
  logic [1:0]           sm, isc;
  ppm_ovr_t [N-1:0]     req, ovr;
  int                   n_fail, tests_run;

  ppm_port_mux #(.NPINS(N)) u_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pad_pu),
    .pad_analog_tap(pad_an), .ovr(ovr), .sleep_clamp(sleep_clamp),
    .alt_fn_raw_input(alt_raw), .global_pullup_disable(gpd), .sleep_enable_bit(se),
    .sleep_mode(sm), .ext_irq_sense(isc)
  );
  ppm_periph_model #(.NPINS(N)) u_periph (
    .pclk(pclk), .presetn(presetn), .req(req), .ovr(ovr)
  );

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (k == 20) begin
      n_fail++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pins(input logic [N-1:0] oe, input logic [N-1:0] o, input logic [N-1:0] pu);
    @(negedge pclk);
    chk("pad_oe", 32'(oe), 32'(pad_oe));
    chk("pad_out", 32'(o), 32'(pad_out));
    chk("pad_pullup", 32'(pu), 32'(pad_pu));
  endtask : pins

  task automatic t_ctrl();
    apb(1'b0, PPM_OFF_MCU, 32'h0);
    chk("mcu_reset", 32'h0, rd);
    apb(1'b1, PPM_OFF_MCU, 32'hff);
    apb(1'b0, PPM_OFF_MCU, 32'h0);
    chk("mcu_read", 32'h7b, rd);
    chk("pud_out", 32'h1, 32'(gpd));
    chk("mcu_fields", 32'h1f, 32'({se, sm, isc}));
  endtask : t_ctrl

  // Pins 0..5 cover {dir,latch} 00,01,10,11,00,01 under both disable settings
  task automatic t_gpio();
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, PPM_OFF_MCU, p ? 32'h40 : 32'h0);
      apb(1'b1, PPM_OFF_LATCH, 32'h2a);
      apb(1'b1, PPM_OFF_DIR, 32'h0c);
      pins(6'h0c, 6'h08, p ? 6'h00 : 6'h22);
    end
  endtask : t_gpio

  // Packed field order: pu_en pu_val dir_en dir_val val_en val_val tog_en in_en in_val
  task automatic t_ovr();
    apb(1'b1, PPM_OFF_MCU, 32'h0);
    req <= {18'h0, 9'h040, 9'h018, 9'h100, 9'h1f8};
    repeat (2) @(posedge pclk);
    pins(6'h05, 6'h05, 6'h21);
    apb(1'b1, PPM_OFF_MCU, 32'h40);
    pins(6'h05, 6'h05, 6'h01);
  endtask : t_ovr

  task automatic t_input();
    @(posedge pclk);
    pad_in <= 6'h37;
    req    <= {36'h0, 9'h003, 9'h002};
    repeat (3) @(posedge pclk);
    apb(1'b0, PPM_OFF_PIN, 32'h0);
    chk("pin_reg", 32'h36, rd);
    @(negedge pclk);
    chk("raw_awake", 32'h36, 32'(alt_raw));
    chk("analog", 32'h37, 32'(pad_an));
    @(posedge pclk);
    sleep_clamp <= 1'b1;
    @(negedge pclk);
    chk("raw_sleep", 32'h02, 32'(alt_raw));
    @(posedge pclk);
    sleep_clamp <= 1'b0;
    req         <= '0;
  endtask : t_input

  task automatic t_toggle();
    apb(1'b1, PPM_OFF_PIN, 32'h03);
    apb(1'b0, PPM_OFF_LATCH, 32'h0);
    chk("latch_pin_wr", 32'h29, rd);
    @(posedge pclk);
    req <= {9'h004, 45'h0};
    @(posedge pclk);
    req <= '0;
    apb(1'b0, PPM_OFF_LATCH, 32'h0);
    chk("latch_toggle", 32'h09, rd);
    apb(1'b1, 8'h10, 32'hff);
    chk("unmapped_err", 32'h1, 32'(er));
    apb(1'b0, PPM_OFF_LATCH, 32'h0);
    chk("latch_kept", 32'h09, rd);
  endtask : t_toggle

  initial begin
    n_fail      = 0;
    tests_run   = 0;
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = '0;
    pwdata      = '0;
    pad_in      = '0;
    sleep_clamp = 1'b0;
    req         = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_ctrl();
    t_gpio();
    t_ovr();
    t_input();
    t_toggle();
    test_done();
  end
endmodule : tb_ppm_port_mux
`default_nettype wire
